/* File: hw/iap_engine.sv */
// I2C script engine for start, address+read and address+write commands with ack polling.
// Assumes the host feeds one script command at a time and keeps scl/sda wired open-drain.
// Function
// - Zero timeout disables acknowledge polling
// - Nonzero timeout: poll until ack or expiry
// - Polling applies after start or restart
// - Timeout persists; resets zero at script end
// - Read command forces direction bit one
// - Write command forces direction bit zero
// - Address bits 7..1, direction bit 0
// - Sample acknowledge slot after eight bits
// - Missing acknowledge enters polling under timeout
// - Timeout counted in milliseconds
`timescale 1ns/10ps
`include "iap_params.svh"
module iap_engine
  import iap_pkg::*;
#(
  parameter int HALF_BIT_CYC = `IAP_HALF_BIT_CYC,
  parameter int CYC_PER_MS   = `IAP_CYC_PER_MS
) (
  input  wire logic     clk_sys,  // System clock, 100 MHz
  input  wire logic     rst,      // Synchronous reset, active high
  input  wire logic     cmd_vld,  // Command offered
  output logic          cmd_rdy,  // Command taken while high with cmd_vld
  input  iap_cmd_s      cmd,      // Script command
  output iap_rsp_s      rsp,      // One-cycle completion pulse and status
  output logic          busy,     // Script running
  input  wire logic     scl_i,    // Clock line level
  output logic          scl_o,    // Clock line drive value, always low
  output logic          scl_oe,   // Pull clock low
  input  wire logic     sda_i,    // Data line level
  output logic          sda_o,    // Data line drive value, always low
  output logic          sda_oe    // Pull data low
);
  if (HALF_BIT_CYC < 2 || CYC_PER_MS < 1) begin : g_bad_timing
    $error("iap_engine: bad timing parameter");
  end

  typedef struct packed {
    iap_st_e     st;
    logic [15:0] tmo_ms;
    logic [7:0]  abyte;
    logic [2:0]  bitn;
    logic [1:0]  ph;
    logic [31:0] div;
    logic [31:0] ms_cnt;
    logic [15:0] ms_left;
    logic        polling;
    logic        scl_lo;
    logic        sda_lo;
    logic        run;
    iap_rsp_s    rsp;
  } iap_state_s;

  iap_state_s s_reg;
  iap_state_s s_next;

  function automatic logic [7:0] addr_byte(input logic [6:0] a, input logic dir);
    return {a, dir};
  endfunction : addr_byte

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next = s_reg;
    s_next.rsp = '0;
    cmd_rdy = (s_reg.st == IAP_ST_IDLE);
    // Millisecond tick keeps running during polling so retries eat into the budget
    if (s_reg.polling) begin
      if (s_reg.ms_cnt == 32'(CYC_PER_MS - 1)) begin
        s_next.ms_cnt = '0;
        if (s_reg.ms_left != 16'h0000) s_next.ms_left = s_reg.ms_left - 16'h0001;
      end else begin
        s_next.ms_cnt = s_reg.ms_cnt + 32'h1;
      end
    end
    if (s_reg.div != 32'h0) s_next.div = s_reg.div - 32'h1;
    case (s_reg.st)
      IAP_ST_IDLE: begin
        if (cmd_vld) begin
          s_next.run = 1'b1;
          case (cmd.op)
            IAP_OP_TMO: begin
              s_next.tmo_ms = cmd.tmo_ms;
              s_next.rsp.done = 1'b1;
            end
            IAP_OP_END: begin
              s_next.tmo_ms = `IAP_TMO_DEFAULT;
              s_next.run = 1'b0;
              s_next.rsp.done = 1'b1;
            end
            IAP_OP_START: begin
              s_next.st = IAP_ST_START;
              s_next.ph = 2'h0;
              s_next.div = 32'(HALF_BIT_CYC);
            end
            IAP_OP_ADRD, IAP_OP_ADWR: begin
              // The bus must already hold a start from an earlier command
              s_next.abyte = addr_byte(cmd.addr, (cmd.op == IAP_OP_ADRD) ?
                                       `IAP_DIR_READ : `IAP_DIR_WRITE);
              s_next.st = IAP_ST_BIT;
              s_next.bitn = `IAP_BIT_FIRST;
              s_next.ph = 2'h0;
              s_next.div = 32'(HALF_BIT_CYC);
              s_next.polling = 1'b0;
              s_next.ms_cnt = '0;
              s_next.ms_left = s_reg.tmo_ms;
            end
            default: s_next.rsp.done = 1'b1;
          endcase
        end
      end
      IAP_ST_START: begin
        // Start or repeated start: release both, then sda low under scl high
        if (s_reg.div == 32'h0) begin
          s_next.div = 32'(HALF_BIT_CYC);
          s_next.ph = s_reg.ph + 2'h1;
          case (s_reg.ph)
            2'h0: s_next.sda_lo = 1'b0;
            2'h1: s_next.scl_lo = 1'b0;
            2'h2: s_next.sda_lo = 1'b1;
            default: begin
              s_next.scl_lo = 1'b1;
              s_next.ph = 2'h0;
              if (s_reg.polling) begin
                s_next.st = IAP_ST_BIT;
                s_next.bitn = `IAP_BIT_FIRST;
              end else begin
                s_next.st = IAP_ST_IDLE;
                s_next.rsp.done = 1'b1;
              end
            end
          endcase
        end
      end
      IAP_ST_BIT, IAP_ST_ACK: begin
        // Phase 0 sets data with scl low, phase 1 raises scl, phase 2 lowers it
        if (s_reg.div == 32'h0) begin
          s_next.div = 32'(HALF_BIT_CYC);
          case (s_reg.ph)
            2'h0: begin
              s_next.sda_lo = (s_reg.st == IAP_ST_BIT) ? !s_reg.abyte[s_reg.bitn] : 1'b0;
              s_next.ph = 2'h1;
            end
            2'h1: begin
              s_next.scl_lo = 1'b0;
              s_next.ph = 2'h2;
            end
            default: begin
              s_next.scl_lo = 1'b1;
              s_next.ph = 2'h0;
              if (s_reg.st == IAP_ST_BIT) begin
                if (s_reg.bitn == `IAP_BIT_LAST) s_next.st = IAP_ST_ACK;
                else s_next.bitn = s_reg.bitn - 3'h1;
              end else if (!sda_i) begin
                s_next.st = IAP_ST_RESP;
                s_next.rsp.ack = 1'b1;
              end else if (s_reg.tmo_ms == 16'h0000) begin
                s_next.st = IAP_ST_RESP;
                s_next.rsp.err = 1'b1;
              end else if (s_reg.polling && s_reg.ms_left == 16'h0000) begin
                s_next.st = IAP_ST_ABORT;
              end else begin
                s_next.polling = 1'b1;
                s_next.st = IAP_ST_START;
              end
            end
          endcase
        end
      end
      IAP_ST_RESP: begin
        s_next.rsp.done = 1'b1;
        s_next.rsp.ack = s_reg.rsp.ack;
        s_next.rsp.err = s_reg.rsp.err;
        s_next.polling = 1'b0;
        s_next.st = IAP_ST_IDLE;
      end
      IAP_ST_ABORT: begin
        // Stop condition ends the bus cycle before the script is dropped
        if (s_reg.div == 32'h0) begin
          s_next.div = 32'(HALF_BIT_CYC);
          s_next.ph = s_reg.ph + 2'h1;
          case (s_reg.ph)
            2'h0: s_next.sda_lo = 1'b1;
            2'h1: s_next.scl_lo = 1'b0;
            default: begin
              s_next.sda_lo = 1'b0;
              s_next.st = IAP_ST_STOP;
            end
          endcase
        end
      end
      IAP_ST_STOP: begin
        s_next.rsp.done = 1'b1;
        s_next.rsp.err = 1'b1;
        s_next.polling = 1'b0;
        s_next.run = 1'b0;
        s_next.tmo_ms = `IAP_TMO_DEFAULT;
        s_next.ph = 2'h0;
        s_next.st = IAP_ST_IDLE;
      end
      default: s_next.st = IAP_ST_IDLE;
    endcase
    // Hold scl while a target stretches it
    if (s_reg.st != IAP_ST_IDLE && !s_reg.scl_lo && scl_i == 1'b0 && s_reg.ph == 2'h2)
      s_next.div = s_reg.div;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.st <= IAP_ST_IDLE;
      s_reg.tmo_ms <= `IAP_TMO_DEFAULT;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rsp    = s_reg.rsp;
  assign busy   = s_reg.run;
  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign scl_oe = s_reg.scl_lo;
  assign sda_oe = s_reg.sda_lo;
endmodule : iap_engine

/* File: hw/iap_params.svh */
// Constants for the I2C script address-phase engine with acknowledge polling.
// Assumes a 100 MHz system clock; included by the package and the engine.
`ifndef IAP_PARAMS_SVH
`define IAP_PARAMS_SVH
`define IAP_CLK_HZ        100000000
`define IAP_MS_PER_S      1000
`define IAP_CYC_PER_MS    (`IAP_CLK_HZ / `IAP_MS_PER_S)
`define IAP_HALF_BIT_CYC  250
`define IAP_TMO_DEFAULT   16'h0000
`define IAP_DIR_READ      1'b1
`define IAP_DIR_WRITE     1'b0
`define IAP_BIT_LAST      3'h0
`define IAP_BIT_FIRST     3'h7
`endif

/* File: hw/iap_pkg.sv */
// Types for the I2C script address-phase engine.
// Assumes iap_params.svh sits on the include path.
`include "iap_params.svh"
package iap_pkg;
  typedef enum logic [2:0] {
    IAP_OP_NONE  = 3'h0,
    IAP_OP_START = 3'h1,
    IAP_OP_ADRD  = 3'h2,
    IAP_OP_ADWR  = 3'h3,
    IAP_OP_TMO   = 3'h4,
    IAP_OP_END   = 3'h5
  } iap_op_e;

  typedef struct packed {
    iap_op_e     op;
    logic [6:0]  addr;
    logic [15:0] tmo_ms;
  } iap_cmd_s;

  typedef struct packed {
    logic done;
    logic ack;
    logic err;
  } iap_rsp_s;

  typedef enum logic [6:0] {
    IAP_ST_IDLE  = 7'h01,
    IAP_ST_START = 7'h02,
    IAP_ST_BIT   = 7'h04,
    IAP_ST_ACK   = 7'h08,
    IAP_ST_STOP  = 7'h10,
    IAP_ST_RESP  = 7'h20,
    IAP_ST_ABORT = 7'h40
  } iap_st_e;
endpackage : iap_pkg

/* File: tb/iap_engine_monitor.sv */
// Port assertions for the address-phase engine, bound onto its top module.
// Assumes scl_i and sda_i carry the resolved open-drain line levels.
`timescale 1ns/10ps
module iap_engine_monitor
  import iap_pkg::*;
#(
  parameter int HALF_BIT_CYC = 3,
  parameter int CYC_PER_MS   = 10
) (
  input wire logic clk_sys,  // System clock
  input wire logic rst,      // Synchronous reset, active high
  input wire logic cmd_vld,  // Command offered
  input wire logic cmd_rdy,  // Command accepted
  input wire logic busy,     // Script running
  input wire logic scl_i,    // Clock line level
  input wire logic scl_o,    // Clock drive value
  input wire logic scl_oe,   // Clock pull-down
  input wire logic sda_i,    // Data line level
  input wire logic sda_o,    // Data drive value
  input wire logic sda_oe,   // Data pull-down
  input iap_cmd_s  cmd,      // Command
  input iap_rsp_s  rsp       // Response
);
  logic [15:0] tmo_reg;
  logic        in_adr_reg;
  wire take = cmd_vld && cmd_rdy;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Shadow timeout, so the checks know whether acknowledge polling is enabled
  always_ff @(posedge clk_sys) begin
    if (rst || (take && cmd.op == IAP_OP_END) || $fell(busy)) tmo_reg <= 16'h0;
    else if (take && cmd.op == IAP_OP_TMO) tmo_reg <= cmd.tmo_ms;
    in_adr_reg <= !rst && ((take && cmd.op inside {IAP_OP_ADRD, IAP_OP_ADWR})
                  || (in_adr_reg && !rsp.done));
  end
  sequence s_start;
    scl_i && $fell(sda_i);
  endsequence
  a_reset_quiet: assert property ($past(rst) |-> !busy && !rsp.done && !scl_oe)
    else $error("engine active after reset");
  a_done_single: assert property (rsp.done |=> !rsp.done)
    else $error("long completion");
  a_addr_verdict: assert property (in_adr_reg && rsp.done |-> rsp.ack != rsp.err)
    else $error("bad address verdict");
  a_no_poll: assert property (in_adr_reg && tmo_reg == 16'h0 |-> not s_start)
    else $error("retry with zero timeout");
  a_tmo_answer: assert property (take && cmd.op == IAP_OP_TMO |=> rsp.done && busy)
    else $error("timeout command not answered");
  a_start_made: assert property (take && cmd.op == IAP_OP_START |-> ##[1:40] s_start)
    else $error("no start condition");
  a_addr_time: assert property (take && cmd.op == IAP_OP_ADWR && tmo_reg == 16'h0
    |-> ##[90:130] rsp.done)
    else $error("address phase length");
  a_abort_end: assert property (rsp.done && rsp.err && in_adr_reg && tmo_reg != 16'h0
    |-> ##[0:2] !busy)
    else $error("abort left script running");
  a_pins_open_drain: assert property (!scl_o && !sda_o)
    else $error("line driven high");
  a_start_refuse: assert property (take && cmd.op == IAP_OP_START |=> !cmd_rdy)
    else $error("ready during start");
endmodule : iap_engine_monitor
bind iap_engine iap_engine_monitor #(.HALF_BIT_CYC(HALF_BIT_CYC), .CYC_PER_MS(CYC_PER_MS)) u_mon (
  .clk_sys(clk_sys), .rst(rst), .cmd_vld(cmd_vld), .cmd_rdy(cmd_rdy), .busy(busy),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .cmd(cmd), .rsp(rsp));

/* File: tb/iap_target_model.sv */
// Behavioural target: answers one address once enough starts were seen.
// Assumes pulled-up lines, so a released data line reads high.
`timescale 1ns/10ps
module iap_target_model (
  input wire logic       scl,               // Clock line level
  input wire logic       sda,               // Data line level
  input wire logic [6:0] my_addr,           // Address answered
  input wire logic [7:0] refuse,            // Start count to pass before answering
  output logic           sda_oe = 1'b0,     // Pull data low
  output logic [7:0]     byte_rx = 8'h0,    // Last address byte
  output logic [7:0]     n_start = 8'h0     // Starts and restarts seen
);
  logic [3:0] bit_cnt = 4'hf;
  logic [7:0] n_seen  = 8'h0;
  always @(negedge sda) if (scl) n_start <= n_start + 8'h1;
  always @(posedge scl) if (bit_cnt < 4'h8) byte_rx <= {byte_rx[6:0], sda};
  // First clock fall after a start opens a byte; saturate so stray clocks never fake a slot
  always @(negedge scl) begin
    sda_oe <= n_seen == n_start && bit_cnt == 4'h7 && byte_rx[7:1] == my_addr
              && n_start > refuse;
    if (n_seen != n_start) begin
      n_seen  <= n_start;
      bit_cnt <= 4'h0;
    end else if (bit_cnt < 4'h9) begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end
endmodule : iap_target_model

/* File: tb/iap_engine_tb.sv */
// Bench for the address-phase engine with one target on the bus.
// Assumes shortened bit and millisecond counts through parameters.
`timescale 1ns/10ps
module iap_engine_tb
  import iap_pkg::*;
;
  logic       clk_sys = 1'b0, rst = 1'b1, cmd_vld = 1'b0, t_oe, cmd_rdy, busy, scl_oe, sda_oe;
  logic [7:0] refuse = 8'h0, rx, n_st, s0;
  iap_cmd_s   cmd = '0;
  iap_rsp_s   rsp, r;
  int         n_fail = 0, samples_checked = 0, cyc = 0;
  wire scl = !scl_oe;
  wire sda = !(sda_oe || t_oe);
  always #5 clk_sys = !clk_sys;
  iap_engine #(.HALF_BIT_CYC(3), .CYC_PER_MS(10)) u_iap_engine (.clk_sys(clk_sys), .rst(rst),
    .cmd_vld(cmd_vld), .cmd_rdy(cmd_rdy), .cmd(cmd), .rsp(rsp), .busy(busy), .scl_i(scl),
    .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
  iap_target_model u_iap_target_model (.scl(scl), .sda(sda), .my_addr(7'h5a),
    .refuse(refuse), .sda_oe(t_oe), .byte_rx(rx), .n_start(n_st));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input iap_op_e op, input logic [6:0] a, input logic [15:0] t);
    @(negedge clk_sys);
    cmd_vld = 1'b1;
    cmd = '{op, a, t};
    @(negedge clk_sys);
    cmd_vld = 1'b0;
    while (rsp.done !== 1'b1) @(negedge clk_sys);
    r = rsp;
  endtask : run
  // Start then address; returns verdict and starts seen
  task automatic adr(input iap_op_e op, input logic [6:0] a);
    s0 = n_st;
    run(IAP_OP_START, 7'h0, 16'h0);
    run(op, a, 16'h0);
  endtask : adr
  task automatic t_ack;
    for (int i = 0; i < 2; i++) begin
      adr(i ? IAP_OP_ADRD : IAP_OP_ADWR, 7'h5a);
      chk(rx, {7'h5a, i[0]});
      chk({5'h0, r}, 8'h06);
    end
    run(IAP_OP_END, 7'h0, 16'h0);
    $display("ack test done");
  endtask : t_ack
  task automatic t_poll;
    run(IAP_OP_TMO, 7'h0, 16'h64);
    run(IAP_OP_NONE, 7'h0, 16'h0);
    chk({5'h0, r}, 8'h04);
    for (int i = 0; i < 2; i++) begin
      refuse = n_st + 8'h2;
      adr(IAP_OP_ADWR, 7'h5a);
      chk({5'h0, r}, 8'h06);
      chk(n_st - s0, 8'h3);
    end
    run(IAP_OP_END, 7'h0, 16'h0);
    adr(IAP_OP_ADRD, 7'h11);
    chk({5'h0, r}, 8'h05);
    chk(n_st - s0, 8'h1);
    run(IAP_OP_END, 7'h0, 16'h0);
    $display("poll test done");
  endtask : t_poll
  task automatic t_abort;
    run(IAP_OP_TMO, 7'h0, 16'h14);
    adr(IAP_OP_ADRD, 7'h11);
    chk({5'h0, r}, 8'h05);
    chk(n_st - s0, 8'h3);
    repeat (3) @(negedge clk_sys);
    chk({7'h0, busy}, 8'h0);
    adr(IAP_OP_ADWR, 7'h11);
    chk(n_st - s0, 8'h1);
    $display("abort test done");
  endtask : t_abort
  task automatic summarize;
    $display("checks=%0d fails=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // Whole run is under two thousand cycles; the ceiling leaves wide margin
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    t_ack();
    t_poll();
    t_abort();
    summarize();
  end
endmodule : iap_engine_tb
